// ---- logic/clock_source_pkg.sv ----
// shared constants, field layouts and types for the clock source unit
package clock_source_pkg;
    // register byte addresses (apb, one 32-bit word each)
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_TRIM = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;

    // output clock select codes
    localparam logic [1:0] SEL_LOOP = 2'h0;
    localparam logic [1:0] SEL_INT = 2'h1;
    localparam logic [1:0] SEL_EXT = 2'h2;

    // bus divider codes
    localparam logic [1:0] BUS_DIVIDER_1 = 2'h0;
    localparam logic [1:0] BUS_DIVIDER_2 = 2'h1;
    localparam logic [1:0] BUS_DIVIDER_4 = 2'h2;

    // lowest reference divider code for a valid fixed clock at bus divide by 1
    localparam logic [2:0] FFV_REF_DIVIDER_BASE = 3'h2;
    localparam logic [2:0] REF_DIVIDER_NONE = 3'h0;

    // loop multiplies by 1024, so its half period is the reference period >> 11
    localparam int LOOP_HALF_SHIFT = 11;
    localparam int MEAS_W = 24;
    localparam logic [MEAS_W-1:0] LOOP_HALF_MIN = 24'h000001;

    // internal reference half period in system cycles is base plus twice the trim register plus the fine trim bit
    localparam logic [9:0] IRC_BASE_HALF = 10'h040;
    localparam int TRIM_W = 8;

    // full cycles of a new clock seen before it is trusted
    localparam logic [2:0] SETTLE_EDGES = 3'h4;

    localparam int CTRL_W = 13;
    localparam int STATUS_W = 6;

    typedef logic [1:0] clk_sel_t;

    typedef struct packed {
        logic ext_ref_stop_enable;
        logic ext_ref_out_enable;
        logic int_ref_stop_enable;
        logic int_ref_out_enable;
        logic low_power_loop_off;
        logic [1:0] bus_divider;
        logic [2:0] ref_divider;
        logic ref_select;
        clk_sel_t out_clock_select;
    } ctrl_t;

    typedef struct packed {
        logic switch_pending;
        logic loop_running;
        logic fixed_freq_valid;
        clk_sel_t clock_status;
        logic ref_select_status;
    } status_t;

    // default mode: loop engaged on the internal reference
    localparam ctrl_t CTRL_RST = '{
        ext_ref_stop_enable: 1'b0,
        ext_ref_out_enable: 1'b0,
        int_ref_stop_enable: 1'b0,
        int_ref_out_enable: 1'b0,
        low_power_loop_off: 1'b0,
        bus_divider: 2'h1,
        ref_divider: 3'h0,
        ref_select: 1'b1,
        out_clock_select: 2'h0
    };
endpackage

// ---- logic/edge_counter.sv ----
// counts rising edges of a sampled clock level after a restart
`timescale 1ns/1ps
module edge_counter
    import clock_source_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rstn,
    // control
    input wire logic restart,
    input wire logic level,
    // result
    output logic done
);
    logic prev_r;
    logic [2:0] count_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level;
        end
    end

    // a stopped clock never reaches the count, so done stays low
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_r <= 3'h0;
        end else if (restart) begin
            count_r <= 3'h0;
        end else if (level && !prev_r && count_r != SETTLE_EDGES) begin
            count_r <= count_r + 3'h1;
        end
    end

    assign done = (count_r == SETTLE_EDGES) && !restart;
endmodule // edge_counter

// ---- logic/clock_source_unit.sv ----
// clock source unit: mode switching, dividers, trim and reference gating
// What this block does
// - loop relocks after few divided reference cycles
// - reference status updates when switch completes
// - output switch waits few new clock cycles
// - stopped new clock keeps old clock selected
// - bus divider acts immediately
// - low power bit turns unused loop off
// - internal reference output when enabled
// - larger trim lengthens internal reference period
// - trim changes output in internal modes
// - trim fields survive every reset
// - internal reference runs in stop when enabled
// - external reference output when enabled
// - internal select keeps external off loop
// - external reference runs in stop when enabled
// - divided reference is fixed frequency clock
// - engaged modes always flag fixed clock valid
// - bypass valid needs divider code threshold
// - loop locks to 1024 times reference
// - select codes loop, internal, external
// - bypass loop off if low power, no debug
`timescale 1ns/1ps
module clock_source_unit
    import clock_source_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // chip state and external reference
    input wire logic stop_mode,
    input wire logic debug_mode,
    input wire logic ext_ref_in,
    // clock outputs
    output logic main_clock_out,
    output logic int_ref_clock_out,
    output logic ext_ref_clock_out,
    output logic fixed_freq_clock,
    output logic fixed_freq_valid
);
    import clock_source_pkg::*;

    typedef enum {SW_IDLE, SW_COUNT, SW_ALIGN} sw_state_t;

    ctrl_t ctrl_r;
    logic [TRIM_W-1:0] trim_register;
    logic fine_trim;
    status_t status;
    logic ref_select_status_r;
    clk_sel_t active_sel_r;
    clk_sel_t target_r;
    sw_state_t sw_state_r;
    logic irc_lvl_r;
    logic [9:0] irc_cnt_r;
    logic [9:0] irc_half;
    logic irc_run;
    logic fll_ref_lvl;
    logic fll_ref_prev_r;
    logic [6:0] ref_cnt_r;
    logic div_ref;
    logic div_ref_prev_r;
    logic [MEAS_W-1:0] per_cnt_r;
    logic [MEAS_W-1:0] meas_r;
    logic [MEAS_W-1:0] loop_half;
    logic [MEAS_W-1:0] loop_cnt_r;
    logic loop_lvl_r;
    logic loop_on;
    logic bypass;
    logic ref_sel_prev_r;
    logic ref_restart;
    logic ref_done;
    logic sw_restart;
    logic sw_done;
    logic act_lvl;
    logic tgt_lvl;
    logic act_prev_r;
    logic [2:0] bus_cnt_r;
    logic main_nxt;
    logic ffv_nxt;
    logic wr_en;
    logic rd_setup;

    function automatic logic src_level(input clk_sel_t sel, input logic loop_l,
                                       input logic irc_l, input logic ext_l);
        logic lvl;
        lvl = 1'b0;
        if (sel == SEL_LOOP) begin
            lvl = loop_l;
        end else if (sel == SEL_INT) begin
            lvl = irc_l;
        end else if (sel == SEL_EXT) begin
            lvl = ext_l;
        end
        return lvl;
    endfunction

    // ---------------- apb slave ----------------
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pslverr = psel && penable && paddr != ADDR_CTRL && paddr != ADDR_TRIM
                     && paddr != ADDR_STATUS;

    // divider and select arrive in one word, so software can move them together
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl_r <= ctrl_t'(pwdata[CTRL_W-1:0]);
        end
    end

    // no reset on purpose: a trimmed reference must not drift back at reset
    always_ff @(posedge clock) begin
        if (wr_en && paddr == ADDR_TRIM) begin
            trim_register <= pwdata[TRIM_W-1:0];
            fine_trim <= pwdata[TRIM_W];
        end
    end

    assign status = '{
        switch_pending: sw_state_r != SW_IDLE,
        loop_running: loop_on,
        fixed_freq_valid: fixed_freq_valid,
        clock_status: active_sel_r,
        ref_select_status: ref_select_status_r
    };

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
        end else if (rd_setup) begin
            if (paddr == ADDR_CTRL) begin
                prdata <= {{(32-CTRL_W){1'b0}}, ctrl_r};
            end else if (paddr == ADDR_TRIM) begin
                prdata <= {{(31-TRIM_W){1'b0}}, fine_trim, trim_register};
            end else if (paddr == ADDR_STATUS) begin
                prdata <= {{(32-STATUS_W){1'b0}}, status};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // ---------------- internal reference oscillator ----------------
    assign irc_half = IRC_BASE_HALF + {1'b0, trim_register, fine_trim};
    assign irc_run = !stop_mode || (ctrl_r.int_ref_out_enable && ctrl_r.int_ref_stop_enable);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irc_cnt_r <= 10'h0;
            irc_lvl_r <= 1'b0;
        end else if (!irc_run) begin
            irc_cnt_r <= 10'h0;
        end else if (irc_cnt_r >= irc_half - 10'h1) begin
            irc_cnt_r <= 10'h0;
            irc_lvl_r <= !irc_lvl_r;
        end else begin
            irc_cnt_r <= irc_cnt_r + 10'h1;
        end
    end

    // ---------------- reference path and fixed frequency clock ----------------
    assign fll_ref_lvl = ctrl_r.ref_select ? irc_lvl_r : ext_ref_in;
    assign div_ref = (ctrl_r.ref_divider == REF_DIVIDER_NONE) ? fll_ref_lvl
                     : ref_cnt_r[ctrl_r.ref_divider - 3'h1];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fll_ref_prev_r <= 1'b0;
            ref_cnt_r <= 7'h0;
        end else begin
            fll_ref_prev_r <= fll_ref_lvl;
            if (fll_ref_lvl && !fll_ref_prev_r) begin
                ref_cnt_r <= ref_cnt_r + 7'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fixed_freq_clock <= 1'b0;
        end else begin
            fixed_freq_clock <= div_ref && !stop_mode;
        end
    end

    // ---------------- frequency-locked loop model ----------------
    assign bypass = ctrl_r.out_clock_select != SEL_LOOP;
    assign loop_on = !(bypass && ctrl_r.low_power_loop_off && !debug_mode)
                     && !stop_mode;

    assign ref_restart = ctrl_r.ref_select != ref_sel_prev_r || !loop_on;

    edge_counter ref_settle (
        .clock(clock),
        .rstn(rstn),
        .restart(ref_restart),
        .level(div_ref),
        .done(ref_done)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref_sel_prev_r <= CTRL_RST.ref_select;
            ref_select_status_r <= CTRL_RST.ref_select;
        end else begin
            ref_sel_prev_r <= ctrl_r.ref_select;
            if (ref_done) begin
                ref_select_status_r <= ctrl_r.ref_select;
            end
        end
    end

    // measure the divided reference period in system cycles
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_ref_prev_r <= 1'b0;
            per_cnt_r <= '0;
            meas_r <= '0;
        end else begin
            div_ref_prev_r <= div_ref;
            if (div_ref && !div_ref_prev_r) begin
                meas_r <= per_cnt_r;
                per_cnt_r <= '0;
            end else if (per_cnt_r != '1) begin
                per_cnt_r <= per_cnt_r + LOOP_HALF_MIN;
            end
        end
    end

    // resolution is limited by the system clock; fine for relative behaviour
    assign loop_half = ((meas_r >> LOOP_HALF_SHIFT) == '0) ? LOOP_HALF_MIN
                       : (meas_r >> LOOP_HALF_SHIFT);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            loop_cnt_r <= '0;
            loop_lvl_r <= 1'b0;
        end else if (!loop_on || !ref_done) begin
            loop_cnt_r <= '0;
            loop_lvl_r <= 1'b0;
        end else if (loop_cnt_r >= loop_half - LOOP_HALF_MIN) begin
            loop_cnt_r <= '0;
            loop_lvl_r <= !loop_lvl_r;
        end else begin
            loop_cnt_r <= loop_cnt_r + LOOP_HALF_MIN;
        end
    end

    // ---------------- output clock switch ----------------
    assign act_lvl = src_level(active_sel_r, loop_lvl_r, irc_lvl_r, ext_ref_in);
    assign tgt_lvl = src_level(target_r, loop_lvl_r, irc_lvl_r, ext_ref_in);
    assign sw_restart = ctrl_r.out_clock_select != target_r || sw_state_r == SW_IDLE;

    edge_counter clk_settle (
        .clock(clock),
        .rstn(rstn),
        .restart(sw_restart),
        .level(tgt_lvl),
        .done(sw_done)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            target_r <= CTRL_RST.out_clock_select;
        end else begin
            target_r <= ctrl_r.out_clock_select;
        end
    end

    // a stopped or reserved target never finishes counting, so the old clock stays
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sw_state_r <= SW_IDLE;
            active_sel_r <= CTRL_RST.out_clock_select;
        end else begin
            case (sw_state_r)
                SW_IDLE: begin
                    if (target_r != active_sel_r) begin
                        sw_state_r <= SW_COUNT;
                    end
                end
                SW_COUNT: begin
                    if (target_r == active_sel_r) begin
                        sw_state_r <= SW_IDLE;
                    end else if (sw_done) begin
                        sw_state_r <= SW_ALIGN;
                    end
                end
                SW_ALIGN: begin
                    if (ctrl_r.out_clock_select != target_r) begin
                        sw_state_r <= SW_COUNT;
                    // the value about to be loaded must be low too; a fast old source
                    // is never low together with its own delayed copy
                    end else if (!act_lvl && !tgt_lvl && !main_nxt) begin
                        active_sel_r <= target_r;
                        sw_state_r <= SW_IDLE;
                    end
                end
                default: sw_state_r <= SW_IDLE;
            endcase
        end
    end

    // bus divider counts edges of the active clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            act_prev_r <= 1'b0;
            bus_cnt_r <= 3'h0;
        end else begin
            act_prev_r <= act_lvl;
            if (act_lvl && !act_prev_r) begin
                bus_cnt_r <= bus_cnt_r + 3'h1;
            end
        end
    end

    always_comb begin
        case (ctrl_r.bus_divider)
            BUS_DIVIDER_1: main_nxt = act_lvl;
            BUS_DIVIDER_2: main_nxt = bus_cnt_r[0];
            BUS_DIVIDER_4: main_nxt = bus_cnt_r[1];
            default: main_nxt = bus_cnt_r[2];
        endcase
    end

    assign ffv_nxt = !bypass
                     || ctrl_r.ref_divider >= FFV_REF_DIVIDER_BASE + {1'b0, ctrl_r.bus_divider};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            main_clock_out <= 1'b0;
            fixed_freq_valid <= 1'b1;
            int_ref_clock_out <= 1'b0;
            ext_ref_clock_out <= 1'b0;
        end else begin
            main_clock_out <= main_nxt && !stop_mode;
            fixed_freq_valid <= ffv_nxt;
            int_ref_clock_out <= ctrl_r.int_ref_out_enable && irc_lvl_r;
            ext_ref_clock_out <= ctrl_r.ext_ref_out_enable && ext_ref_in
                && (!stop_mode || ctrl_r.ext_ref_stop_enable);
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_out_clock_select_write;
        wr_en && paddr == ADDR_CTRL && pwdata[1:0] != ctrl_r.out_clock_select;
    endsequence

    sequence s_settled;
        $past(sw_done) && $past(sw_state_r) == SW_ALIGN;
    endsequence

    a_ffv_engaged: assert property (!$past(bypass) |-> fixed_freq_valid)
        else $error("fixed clock valid low in engaged mode");
    a_ffv_bypass: assert property ($past(bypass) |-> fixed_freq_valid ==
        ($past(ctrl_r.ref_divider) >= FFV_REF_DIVIDER_BASE + {1'b0, $past(ctrl_r.bus_divider)}))
        else $error("fixed clock valid wrong in bypass mode");
    a_loop_lowpower: assert property (bypass && ctrl_r.low_power_loop_off && !debug_mode
        |-> ##1 !loop_lvl_r)
        else $error("loop ran in low power bypass");
    a_status_wait: assert property ($changed(ref_select_status_r) |-> $past(ref_done))
        else $error("reference status moved before switch done");
    a_switch_hold: assert property ($changed(active_sel_r) |-> s_settled)
        else $error("output clock switched early");
    a_switch_start: assert property (s_out_clock_select_write ##1 (ctrl_r.out_clock_select != active_sel_r)
        |-> ##2 sw_state_r != SW_IDLE [*2])
        else $error("clock switch not pending after select write");
    a_ext_not_fll: assert property (ctrl_r.ref_select |-> fll_ref_lvl == irc_lvl_r)
        else $error("external reference reached the loop");
    a_irclk_gate: assert property (!ctrl_r.int_ref_out_enable |=> !int_ref_clock_out)
        else $error("internal reference out while disabled");
    a_erclk_stop: assert property (stop_mode && !ctrl_r.ext_ref_stop_enable
        |=> !ext_ref_clock_out)
        else $error("external reference out during stop");
    a_ffclk_follow: assert property (fixed_freq_clock == ($past(div_ref) && !$past(stop_mode)))
        else $error("fixed clock not following divided reference");
    a_glitch_free: assert property ($changed(active_sel_r) |-> !$past(act_lvl)
        && !$past(tgt_lvl) && !$past(main_nxt))
        else $error("clock switched during high phase");
endmodule // clock_source_unit

// ---- test/ext_ref_osc.sv ----
// external reference oscillator model feeding the clock source unit
`timescale 1ns/1ps
module ext_ref_osc #(
    parameter int HALF_NS = 1000
) (
    // control
    input wire logic run,
    // oscillator output
    output logic ext_ref_in
);
    // a stopped oscillator freezes at its last level, so no edge leaks out
    // 500 khz by default; edges land on falling system clock edges, never on sampling ones
    initial begin
        ext_ref_in = 1'b0;
        forever begin
            #(HALF_NS);
            if (run) begin
                ext_ref_in = ~ext_ref_in;
            end
        end
    end
endmodule // ext_ref_osc

// ---- test/tb.sv ----
// self-checking bench for the clock source unit
`timescale 1ns/1ps
module tb;
    import clock_source_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic stop_mode = 1'b0;
    logic debug_mode = 1'b0;
    logic osc_run = 1'b1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, ext_ref_in, main_clock_out, int_ref_clock_out;
    logic ext_ref_clock_out, fixed_freq_clock, fixed_freq_valid;
    logic [3:0] outs, prv;
    int edg[4] = '{0, 0, 0, 0};
    int dif[4], lo[4];
    int n_errors = 0;
    int num_checks = 0;
    ctrl_t cfg;

    always #5 clock = ~clock;

    clock_source_unit u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_mode(stop_mode), .debug_mode(debug_mode),
        .ext_ref_in(ext_ref_in), .main_clock_out(main_clock_out),
        .int_ref_clock_out(int_ref_clock_out), .ext_ref_clock_out(ext_ref_clock_out),
        .fixed_freq_clock(fixed_freq_clock), .fixed_freq_valid(fixed_freq_valid));

    ext_ref_osc u_osc (.run(osc_run), .ext_ref_in(ext_ref_in));

    // rising edges of every clock output, seen at system clock rate
    assign outs = {fixed_freq_clock, ext_ref_clock_out, int_ref_clock_out, main_clock_out};
    always @(posedge clock) begin
        prv <= outs;
        foreach (edg[i]) begin
            if (outs[i] === 1'b1 && prv[i] === 1'b0) begin
                edg[i] <= edg[i] + 1;
            end
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so the next call never drives psel in this same step
        @(posedge clock);
    endtask

    task automatic put();
        apb(1'b1, ADDR_CTRL, {19'h0, cfg}, rd, er);
    endtask

    // poll status until the masked field matches, at most n reads
    task automatic wait_st(input logic [31:0] mask, input logic [31:0] val, input int n);
        int k;
        k = 0;
        do begin
            apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
            k++;
        end while ((rd & mask) !== val && k < n);
        check("status", rd & mask, val);
    endtask

    task automatic measure(input int n);
        int base[4];
        base = edg;
        repeat (n) @(posedge clock);
        foreach (dif[i]) dif[i] = edg[i] - base[i];
    endtask

    task automatic t_reset();
        // trim has no reset value, so it is loaded before anything leans on it
        apb(1'b1, ADDR_TRIM, 32'h0, rd, er);
        apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
        check("ctrl reset", rd, {19'h0, CTRL_RST});
        apb(1'b1, ADDR_TRIM, 32'h15a, rd, er);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        apb(1'b0, ADDR_TRIM, 32'h0, rd, er);
        check("trim kept", rd, 32'h15a);
        check("mapped err", {31'h0, er}, 32'h0);
        apb(1'b1, ADDR_TRIM, 32'h0, rd, er);
        apb(1'b0, 12'h00c, 32'h0, rd, er);
        check("unmapped data", rd, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
    endtask

    task automatic t_ffv();
        for (int b = 0; b < 4; b++) begin
            for (int r = 0; r < 8; r++) begin
                cfg.bus_divider = 2'(b);
                cfg.ref_divider = 3'(r);
                cfg.out_clock_select = SEL_INT;
                put();
                repeat (2) @(posedge clock);
                check("valid bypass", {31'h0, fixed_freq_valid}, 32'(r >= b + 2));
                cfg.out_clock_select = SEL_LOOP;
                put();
                repeat (2) @(posedge clock);
                check("valid engaged", {31'h0, fixed_freq_valid}, 32'h1);
            end
        end
    endtask

    task automatic t_switch();
        cfg = CTRL_RST;
        cfg.bus_divider = BUS_DIVIDER_1;
        cfg.int_ref_out_enable = 1'b1;
        cfg.ext_ref_out_enable = 1'b1;
        put();
        wait_st(32'h6, 32'h0, 500);
        cfg.out_clock_select = SEL_INT;
        put();
        // four internal reference periods take well over 300 cycles
        repeat (300) @(posedge clock);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
        check("early switch", rd & 32'h26, 32'h20);
        wait_st(32'h26, 32'h2, 1000);
    endtask

    task automatic t_trim();
        measure(2560);
        lo = dif;
        apb(1'b1, ADDR_TRIM, 32'h20, rd, er);
        measure(2560);
        check("trim slows ref", 32'(dif[1] < lo[1]), 32'h1);
        check("trim slows out", 32'(dif[0] < lo[0]), 32'h1);
        apb(1'b1, ADDR_TRIM, 32'h0, rd, er);
        cfg.bus_divider = BUS_DIVIDER_2;
        put();
        measure(2560);
        check("bus divide", 32'(dif[0] < lo[0] && dif[0] > 0), 32'h1);
        cfg.bus_divider = BUS_DIVIDER_1;
        put();
    endtask

    task automatic t_gate();
        measure(2560);
        check("outs run", 32'(dif[1] > 0 && dif[2] > 0 && dif[3] > 0), 32'h1);
        stop_mode <= 1'b1;
        repeat (4) @(posedge clock);
        measure(2560);
        check("stop quiet", 32'(dif[0] + dif[1] + dif[2] + dif[3]), 32'h0);
        cfg.int_ref_stop_enable = 1'b1;
        cfg.ext_ref_stop_enable = 1'b1;
        put();
        measure(2560);
        check("stop run", 32'(dif[1] > 0 && dif[2] > 0 && dif[0] + dif[3] == 0), 32'h1);
        stop_mode <= 1'b0;
        cfg.int_ref_out_enable = 1'b0;
        cfg.ext_ref_out_enable = 1'b0;
        put();
        measure(2560);
        check("outs gated", 32'(dif[1] + dif[2]), 32'h0);
    endtask

    task automatic t_loop();
        cfg.low_power_loop_off = 1'b1;
        put();
        wait_st(32'h10, 32'h0, 8);
        debug_mode <= 1'b1;
        wait_st(32'h10, 32'h10, 8);
        debug_mode <= 1'b0;
        cfg.low_power_loop_off = 1'b0;
        put();
        wait_st(32'h10, 32'h10, 8);
    endtask

    task automatic t_ext();
        osc_run <= 1'b0;
        cfg.out_clock_select = SEL_EXT;
        put();
        repeat (2000) @(posedge clock);
        measure(1280);
        check("old clock kept", 32'(dif[0] > 0), 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
        check("switch held", rd & 32'h26, 32'h22);
        osc_run <= 1'b1;
        wait_st(32'h6, 32'h4, 1000);
        // 500 khz over 16 keeps the divided reference at 31.25 khz
        cfg.ref_select = 1'b0;
        cfg.ref_divider = 3'h4;
        put();
        apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
        check("ref status early", rd & 32'h1, 32'h1);
        wait_st(32'h1, 32'h0, 8000);
    endtask

    initial begin
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        cfg = CTRL_RST;
        t_reset();
        t_ffv();
        t_switch();
        t_trim();
        t_gate();
        t_loop();
        t_ext();
        test_done();
    end

    initial begin
        #800000;
        n_errors++;
        test_done();
    end
endmodule // tb
